// ### logic/fpec_block_map.sv
// Erase block decoder: one-hot select to registered address range
`timescale 1ns/1ps
`include "fpec_defs.svh"

module fpec_block_map
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Selection
    input wire logic [4:0] sel,
    // Decoded range
    output logic blk_valid,
    output logic [14:0] blk_base,
    output logic [14:0] blk_last
);

    // ==========================================
    // Decode
    logic next_valid;
    logic [14:0] next_base;
    logic [14:0] next_last;

    always_comb
    begin
        next_valid = 1'b1;
        next_base = `FPEC_RST_ADDR;
        next_last = `FPEC_RST_ADDR;
        unique case (sel)
            5'h01:
            begin
                next_base = `FPEC_BLK0_BASE;
                next_last = `FPEC_BLK0_LAST;
            end
            5'h02:
            begin
                next_base = `FPEC_BLK1_BASE;
                next_last = `FPEC_BLK1_LAST;
            end
            5'h04:
            begin
                next_base = `FPEC_BLK2_BASE;
                next_last = `FPEC_BLK2_LAST;
            end
            5'h08:
            begin
                next_base = `FPEC_BLK3_BASE;
                next_last = `FPEC_BLK3_LAST;
            end
            5'h10:
            begin
                next_base = `FPEC_BLK4_BASE;
                next_last = `FPEC_BLK4_LAST;
            end
            default:
            begin
                next_valid = 1'b0;
            end
        endcase
    end

    // ==========================================
    // Output registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blk_valid <= 1'b0;
            blk_base <= `FPEC_RST_ADDR;
            blk_last <= `FPEC_RST_ADDR;
        end
        else
        begin
            blk_valid <= next_valid;
            blk_base <= next_base;
            blk_last <= next_last;
        end
    end

endmodule

// ### logic/fpec_defs.svh
// Register offsets, field positions, reset values and block address map
`ifndef FPEC_DEFS_SVH
`define FPEC_DEFS_SVH

// ==========================================
// Register offsets
`define FPEC_OFS_MODE_CONTROL 4'h0
`define FPEC_OFS_ERROR_STATUS 4'h1
`define FPEC_OFS_BLOCK_SELECT 4'h2
`define FPEC_OFS_ACCESS_REG 4'h3

// ==========================================
// Mode control fields
`define FPEC_BIT_RESERVED 7
`define FPEC_BIT_WRITE_PERMIT 6
`define FPEC_BIT_WIPE_SETUP 5
`define FPEC_BIT_BURN_SETUP 4
`define FPEC_BIT_WASH_CHECK 3
`define FPEC_BIT_BURN_CHECK 2
`define FPEC_BIT_ERASE 1
`define FPEC_BIT_PROGRAM 0

// ==========================================
// Status, select and access fields
`define FPEC_BIT_FAULT_FLAG 7
`define FPEC_BIT_ACCESS_ENABLE 7
`define FPEC_SEL_WIDTH 5

// ==========================================
// Reset values
`define FPEC_RST_MODE_CONTROL 7'h00
`define FPEC_RST_BLOCK_SELECT 5'h00
`define FPEC_RST_ADDR 15'h0000

// ==========================================
// Erase block address map
`define FPEC_BLK0_BASE 15'h0000
`define FPEC_BLK0_LAST 15'h03ff
`define FPEC_BLK1_BASE 15'h0400
`define FPEC_BLK1_LAST 15'h07ff
`define FPEC_BLK2_BASE 15'h0800
`define FPEC_BLK2_LAST 15'h0bff
`define FPEC_BLK3_BASE 15'h0c00
`define FPEC_BLK3_LAST 15'h0fff
`define FPEC_BLK4_BASE 15'h1000
`define FPEC_BLK4_LAST 15'h7fff

`endif

// ### logic/fpec_flash_ctrl.sv
// Flash program/erase mode control with its register port
// Operation
// - Program or erase allowed only while write_permit (bit 6) is 1.
// - With write_permit 0, other mode bits and block select bits cannot be set.
// - Bit 5 enters wipe setup state; clearing it leaves.
// - Bit 4 enters burn setup state; clearing it leaves.
// - Bit 3 enters erase-verify mode; clearing it ends it.
// - Bit 2 enters program-verify mode; clearing it ends it.
// - Bit 1 erases only with write_permit and wipe_setup both 1.
// - Bit 0 programs only with write_permit and burn_setup both 1.
// - A fault during program or erase sets fault_flag, status bit 7.
// - While fault_flag is 1 the flash stays in error protection.
// - Block select held at zero while write_permit is 0.
// - Writing more than one select bit clears the whole block select.
// - Select bit 4 targets the 28-kbyte block 1000h to 7fffh.
// - Select bits 3..0 target 1-kbyte blocks from 0000h up to 0c00h.
// - Reserved mode bit 7 always reads 0.
// - Control registers reachable only while ctrl_access_enable is 1.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "fpec_defs.svh"

module fpec_flash_ctrl
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Flash array feedback
    input wire logic array_fault,
    // Mode outputs to the flash array
    output fpec_pkg::fpec_state_t flash_state,
    output logic wipe_prep,
    output logic burn_prep,
    output logic wipe_active,
    output logic burn_active,
    output logic wash_verify,
    output logic burn_verify,
    output logic error_protect,
    // Erase target
    output logic erase_target_valid,
    output logic [14:0] erase_target_base,
    output logic [14:0] erase_target_last
);

    // ==========================================
    // Register state
    logic ctrl_access_enable;
    logic write_permit;
    logic wipe_setup;
    logic burn_setup;
    logic wash_check;
    logic burn_check;
    logic erase_bit;
    logic program_bit;
    logic fault_flag;
    logic [4:0] erase_block_select;

    // ==========================================
    // Decode helpers
    // One offset compare shared by the write and read paths
    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
        return addr == ofs;
    endfunction

    // A mode bit lands only under a standing permit
    function automatic logic gated_bit(input logic bit_in, input logic gate);
        return bit_in && gate;
    endfunction

    // ==========================================
    // Access decode
    logic ctrl_open;
    logic wr_access;
    logic wr_mode;
    logic wr_select;
    logic [4:0] sel_wdata;

    // Only the access register itself is reachable when closed
    assign ctrl_open = ctrl_access_enable;
    assign wr_access = reg_wr && reg_hit(reg_addr, `FPEC_OFS_ACCESS_REG);
    assign wr_mode = reg_wr && ctrl_open && reg_hit(reg_addr, `FPEC_OFS_MODE_CONTROL);
    assign wr_select = reg_wr && ctrl_open && reg_hit(reg_addr, `FPEC_OFS_BLOCK_SELECT);
    assign sel_wdata = reg_wdata[`FPEC_SEL_WIDTH-1:0];

    // ==========================================
    // Access enable register
    // Always reachable, or software could never open the others
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_access_enable <= 1'b0;
        end
        else if (wr_access)
        begin
            ctrl_access_enable <= reg_wdata[`FPEC_BIT_ACCESS_ENABLE];
        end
    end

    // ==========================================
    // Mode control register
    logic next_permit;
    logic permit_gate;

    // Other bits only land when permit was already set and stays set
    assign next_permit = reg_wdata[`FPEC_BIT_WRITE_PERMIT];
    assign permit_gate = write_permit && next_permit;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {write_permit, wipe_setup, burn_setup, wash_check, burn_check, erase_bit, program_bit}
                <= `FPEC_RST_MODE_CONTROL;
        end
        else if (wr_mode)
        begin
            write_permit <= next_permit;
            wipe_setup <= gated_bit(reg_wdata[`FPEC_BIT_WIPE_SETUP], permit_gate);
            burn_setup <= gated_bit(reg_wdata[`FPEC_BIT_BURN_SETUP], permit_gate);
            wash_check <= gated_bit(reg_wdata[`FPEC_BIT_WASH_CHECK], permit_gate);
            burn_check <= gated_bit(reg_wdata[`FPEC_BIT_BURN_CHECK], permit_gate);
            erase_bit <= gated_bit(reg_wdata[`FPEC_BIT_ERASE], permit_gate);
            program_bit <= gated_bit(reg_wdata[`FPEC_BIT_PROGRAM], permit_gate);
        end
    end

    // ==========================================
    // Erase block select register
    logic sel_conflict;

    // Two or more ones would name several ranges, so the whole select is cleared to zero
    assign sel_conflict = fpec_pkg::fpec_multi_sel(sel_wdata);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            erase_block_select <= `FPEC_RST_BLOCK_SELECT;
        end
        else if (!write_permit || (wr_mode && !next_permit))
        begin
            // Dropping permit wipes the target at once
            erase_block_select <= `FPEC_RST_BLOCK_SELECT;
        end
        else if (wr_select)
        begin
            if (sel_conflict)
            begin
                erase_block_select <= `FPEC_RST_BLOCK_SELECT;
            end
            else
            begin
                erase_block_select <= sel_wdata;
            end
        end
    end

    // ==========================================
    // Fault flag
    logic op_running;

    // Fault reports outside an operation are not ours to latch
    assign op_running = (flash_state == fpec_pkg::FPEC_WIPING) || (flash_state == fpec_pkg::FPEC_BURNING);

    // Cleared only by reset; software has no way to clear it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_flag <= 1'b0;
        end
        else if (array_fault && op_running)
        begin
            fault_flag <= 1'b1;
        end
    end

    // ==========================================
    // Mode state machine
    fpec_pkg::fpec_state_t next_state;
    logic erase_ok;
    logic program_ok;

    assign erase_ok = write_permit && wipe_setup && erase_bit;
    assign program_ok = write_permit && burn_setup && program_bit;

    // Protection outranks every mode so a fault stops work at once
    always_comb
    begin
        if (fault_flag)
        begin
            next_state = fpec_pkg::FPEC_PROTECT;
        end
        else if (erase_ok)
        begin
            next_state = fpec_pkg::FPEC_WIPING;
        end
        else if (program_ok)
        begin
            next_state = fpec_pkg::FPEC_BURNING;
        end
        else if (wash_check)
        begin
            next_state = fpec_pkg::FPEC_WASH_VERIFY;
        end
        else if (burn_check)
        begin
            next_state = fpec_pkg::FPEC_BURN_VERIFY;
        end
        else if (wipe_setup)
        begin
            next_state = fpec_pkg::FPEC_WIPE_PREP;
        end
        else if (burn_setup)
        begin
            next_state = fpec_pkg::FPEC_BURN_PREP;
        end
        else
        begin
            next_state = fpec_pkg::FPEC_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_state <= fpec_pkg::FPEC_IDLE;
        end
        else
        begin
            flash_state <= next_state;
        end
    end

    // ==========================================
    // Mode output flags
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wipe_prep <= 1'b0;
            burn_prep <= 1'b0;
            wipe_active <= 1'b0;
            burn_active <= 1'b0;
            wash_verify <= 1'b0;
            burn_verify <= 1'b0;
            error_protect <= 1'b0;
        end
        else
        begin
            // Setup levels stand under an active operation too
            wipe_prep <= wipe_setup && !fault_flag;
            burn_prep <= burn_setup && !fault_flag;
            wipe_active <= next_state == fpec_pkg::FPEC_WIPING;
            burn_active <= next_state == fpec_pkg::FPEC_BURNING;
            wash_verify <= next_state == fpec_pkg::FPEC_WASH_VERIFY;
            burn_verify <= next_state == fpec_pkg::FPEC_BURN_VERIFY;
            error_protect <= fault_flag;
        end
    end

    // ==========================================
    // Erase target decode
    fpec_block_map u_block_map
    (
        .clk(clk),
        .rst_n(rst_n),
        .sel(erase_block_select),
        .blk_valid(erase_target_valid),
        .blk_base(erase_target_base),
        .blk_last(erase_target_last)
    );

    // ==========================================
    // Read port
    // Closed registers read as zero rather than stale contents
    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_hit(reg_addr, `FPEC_OFS_ACCESS_REG))
        begin
            next_rdata[`FPEC_BIT_ACCESS_ENABLE] = ctrl_access_enable;
        end
        else if (ctrl_open)
        begin
            unique case (reg_addr)
                `FPEC_OFS_MODE_CONTROL:
                begin
                    next_rdata[`FPEC_BIT_RESERVED] = 1'b0;
                    next_rdata[`FPEC_BIT_WRITE_PERMIT] = write_permit;
                    next_rdata[`FPEC_BIT_WIPE_SETUP] = wipe_setup;
                    next_rdata[`FPEC_BIT_BURN_SETUP] = burn_setup;
                    next_rdata[`FPEC_BIT_WASH_CHECK] = wash_check;
                    next_rdata[`FPEC_BIT_BURN_CHECK] = burn_check;
                    next_rdata[`FPEC_BIT_ERASE] = erase_bit;
                    next_rdata[`FPEC_BIT_PROGRAM] = program_bit;
                end
                `FPEC_OFS_ERROR_STATUS:
                begin
                    next_rdata[`FPEC_BIT_FAULT_FLAG] = fault_flag;
                end
                `FPEC_OFS_BLOCK_SELECT:
                begin
                    next_rdata[`FPEC_SEL_WIDTH-1:0] = erase_block_select;
                end
                default:
                begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // Status writes fall through: the status register has no write path
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ### logic/fpec_pkg.sv
// Types and shared helpers of the flash program/erase control block
package fpec_pkg;

    // ==========================================
    // Flash operating state
    typedef enum logic [2:0]
    {
        FPEC_IDLE = 3'b000,
        FPEC_WIPE_PREP = 3'b001,
        FPEC_BURN_PREP = 3'b010,
        FPEC_WIPING = 3'b011,
        FPEC_BURNING = 3'b100,
        FPEC_WASH_VERIFY = 3'b101,
        FPEC_BURN_VERIFY = 3'b110,
        FPEC_PROTECT = 3'b111
    } fpec_state_t;

    // ==========================================
    // More than one select bit set
    function automatic logic fpec_multi_sel(input logic [4:0] sel);
        logic [2:0] count;
        count = 3'h0;
        for (int i = 0; i < 5; i++)
        begin
            count = count + {2'h0, sel[i]};
        end
        return count > 3'h1;
    endfunction

endpackage

// ### verification/fpec_flash_ctrl_sva.sv
// Port checker for the flash program/erase control block
`timescale 1ns/1ps

module fpec_flash_ctrl_sva
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Array side
    input wire logic array_fault,
    input wire logic [2:0] flash_state,
    input wire logic wipe_prep,
    input wire logic burn_prep,
    input wire logic wipe_active,
    input wire logic burn_active,
    input wire logic wash_verify,
    input wire logic burn_verify,
    input wire logic error_protect,
    // Erase target
    input wire logic erase_target_valid,
    input wire logic [14:0] erase_target_base,
    input wire logic [14:0] erase_target_last
);
    // ==========================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_mode_reserved: assert property (reg_rd && reg_addr == 4'h0 |=> !reg_rdata[7])
        else $error("mode reserved bit read as one");
    a_status_reserved: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[6:0] == 7'h00)
        else $error("status reserved bits not zero");
    a_fault_protect: assert property ((flash_state == fpec_pkg::FPEC_WIPING
        || flash_state == fpec_pkg::FPEC_BURNING) && array_fault |-> ##[1:3] error_protect)
        else $error("fault did not reach protection");
    a_protect_hold: assert property (error_protect |=> error_protect)
        else $error("protection dropped without reset");
    a_protect_state: assert property (error_protect |-> flash_state == fpec_pkg::FPEC_PROTECT
        && !wipe_prep && !burn_prep)
        else $error("protection state or prep wrong");
    a_wipe_state: assert property (wipe_active && !error_protect |-> flash_state == fpec_pkg::FPEC_WIPING)
        else $error("erase mode without erase state");
    a_wipe_cause: assert property ($rose(wipe_active) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 4'h0
        && ($past(reg_wdata, 2) & 8'h62) == 8'h62)
        else $error("erase mode without matching write");
    // Entry must trace back to one write carrying permit, setup and mode bit
    a_burn_cause: assert property ($rose(burn_active) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 4'h0
        && ($past(reg_wdata, 2) & 8'h51) == 8'h51)
        else $error("program mode without matching write");
    a_verify_cause: assert property ($rose(wash_verify) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 4'h0
        && ($past(reg_wdata, 2) & 8'h48) == 8'h48)
        else $error("erase verify without matching write");
    a_target_map: assert property (erase_target_valid |->
        {erase_target_base, erase_target_last} inside {{15'h0000, 15'h03ff}, {15'h0400, 15'h07ff},
        {15'h0800, 15'h0bff}, {15'h0c00, 15'h0fff}, {15'h1000, 15'h7fff}})
        else $error("erase target range wrong");
    a_target_none: assert property (!erase_target_valid |-> erase_target_base == 15'h0000
        && erase_target_last == 15'h0000)
        else $error("erase target not cleared");

    // ==========================================
    // Coverage
    cover property (wipe_active);
    cover property (burn_active);
    cover property (error_protect);
    cover property (erase_target_valid);
endmodule

// ### verification/testbench.sv
// Self-checking bench for the flash program/erase control block
`timescale 1ns/1ps

module testbench;
    // ==========================================
    // Signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic array_fault = 1'b0;
    logic [7:0] reg_rdata;
    fpec_pkg::fpec_state_t flash_state;
    logic wipe_prep, burn_prep, wipe_active, burn_active, wash_verify, burn_verify, error_protect;
    logic erase_target_valid;
    logic [14:0] erase_target_base, erase_target_last;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    fpec_flash_ctrl i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .array_fault(array_fault),
        .flash_state(flash_state), .wipe_prep(wipe_prep), .burn_prep(burn_prep), .wipe_active(wipe_active),
        .burn_active(burn_active), .wash_verify(wash_verify), .burn_verify(burn_verify),
        .error_protect(error_protect), .erase_target_valid(erase_target_valid),
        .erase_target_base(erase_target_base), .erase_target_last(erase_target_last));

    // ==========================================
    // Shared tasks
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [14:0] exp, input logic [14:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, {7'h00, exp}, {7'h00, reg_rdata});
    endtask

    // Outputs lag the register by an edge, so wait past both
    task automatic chk_mode(input logic [2:0] st, input logic [6:0] lv);
        repeat (3) @(posedge clk);
        #1;
        chk("flash_state", {12'h000, st}, {12'h000, flash_state});
        chk("mode levels", {8'h00, lv}, {8'h00, wipe_prep, burn_prep, wipe_active, burn_active,
            wash_verify, burn_verify, error_protect});
    endtask

    // ==========================================
    // Scenarios
    task automatic s_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        chk_mode(3'h0, 7'h00);
    endtask

    task automatic s_access;
        wr(4'h0, 8'h40);
        wr(4'h3, 8'h80);
        rd_chk("gated mode write", 4'h0, 8'h00);
        rd_chk("status reset", 4'h1, 8'h00);
        rd_chk("select reset", 4'h2, 8'h00);
    endtask

    task automatic s_permit;
        logic [14:0] base_tab [5] = '{15'h0000, 15'h0400, 15'h0800, 15'h0c00, 15'h1000};
        logic [14:0] last_tab [5] = '{15'h03ff, 15'h07ff, 15'h0bff, 15'h0fff, 15'h7fff};
        wr(4'h2, 8'h01);
        rd_chk("select without permit", 4'h2, 8'h00);
        wr(4'h0, 8'h7f);
        rd_chk("permit only", 4'h0, 8'h40);
        chk_mode(3'h0, 7'h00);
        for (int i = 0; i < 5; i++)
        begin
            wr(4'h2, 8'h01 << i);
            rd_chk("select value", 4'h2, 8'h01 << i);
            chk_mode(3'h0, 7'h00);
            chk("target base", base_tab[i], erase_target_base);
            chk("target last", last_tab[i], erase_target_last);
            chk("target valid", 15'h0001, {14'h0000, erase_target_valid});
        end
        wr(4'h2, 8'h03);
        rd_chk("multi select", 4'h2, 8'h00);
        wr(4'h2, 8'h04);
        wr(4'h0, 8'h00);
        rd_chk("select on permit clear", 4'h2, 8'h00);
        chk_mode(3'h0, 7'h00);
        chk("target dropped", 15'h0000, {14'h0000, erase_target_valid});
    endtask

    task automatic s_modes;
        logic [7:0] bit_tab [4] = '{8'h20, 8'h10, 8'h08, 8'h04};
        logic [2:0] st_tab [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
        logic [6:0] lv_tab [4] = '{7'h40, 7'h20, 7'h04, 7'h02};
        wr(4'h0, 8'h40);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h0, 8'h40 | bit_tab[i]);
            chk_mode(st_tab[i], lv_tab[i]);
            wr(4'h0, 8'h40);
            chk_mode(3'h0, 7'h00);
        end
        // A fault report outside erase or program must not count
        @(posedge clk);
        array_fault <= 1'b1;
        @(posedge clk);
        array_fault <= 1'b0;
        chk_mode(3'h0, 7'h00);
    endtask

    task automatic s_erase;
        wr(4'h0, 8'h42);
        chk_mode(3'h0, 7'h00);
        wr(4'h0, 8'h60);
        wr(4'h0, 8'h62);
        chk_mode(3'h3, 7'h50);
        wr(4'h0, 8'h60);
        chk_mode(3'h1, 7'h40);
        wr(4'h0, 8'h41);
        chk_mode(3'h0, 7'h00);
        wr(4'h0, 8'h50);
        wr(4'h0, 8'h51);
        chk_mode(3'h4, 7'h28);
    endtask

    task automatic s_fault;
        @(posedge clk);
        array_fault <= 1'b1;
        @(posedge clk);
        array_fault <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("protect state", 15'h0007, {12'h000, flash_state});
        chk("protect prep", 15'h0001, {12'h000, wipe_prep, burn_prep, error_protect});
        rd_chk("fault flag", 4'h1, 8'h80);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h40);
        rd_chk("status kept", 4'h1, 8'h80);
        chk("still protected", 15'h0001, {14'h0000, error_protect});
    endtask

    // ==========================================
    // Main sequence and hang guard
    initial
    begin
        s_reset;
        s_access;
        s_permit;
        s_modes;
        s_erase;
        s_fault;
        s_reset;
        wr(4'h3, 8'h80);
        rd_chk("status after reset", 4'h1, 8'h00);
        complete_run;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            complete_run;
        end
    end
endmodule

bind fpec_flash_ctrl fpec_flash_ctrl_sva i_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .array_fault(array_fault),
    .flash_state(flash_state), .wipe_prep(wipe_prep), .burn_prep(burn_prep), .wipe_active(wipe_active),
    .burn_active(burn_active), .wash_verify(wash_verify), .burn_verify(burn_verify),
    .error_protect(error_protect), .erase_target_valid(erase_target_valid),
    .erase_target_base(erase_target_base), .erase_target_last(erase_target_last));
